/* core/host_register_access_port.sv */
// Host register access port with one parallel bus and two redundant serial links.
module host_register_access_port
  import host_port_pkg::*;
(
  // Clock and reset.
  input  wire logic                             i_mclk,
  input  wire logic                             i_rst,
  // Interface select pins.
  input  wire logic                             i_link_a_select_n,
  input  wire logic                             i_link_b_select_n,
  // Parallel bus.
  input  wire logic [host_port_pkg::ADDR_W-1:0] i_parallel_register_address,
  input  wire logic [host_port_pkg::DATA_W-1:0] i_parallel_data_byte,
  output logic      [host_port_pkg::DATA_W-1:0] o_parallel_data_byte,
  output logic                                  o_parallel_data_oe_n,
  input  wire logic                             i_parallel_parity_bit,
  output logic                                  o_parallel_parity_bit,
  output logic                                  o_parallel_parity_oe_n,
  input  wire logic                             i_chip_enable_n,
  input  wire logic                             i_output_enable_n,
  input  wire logic                             i_write_enable_n,
  // Serial link A.
  input  wire logic                             i_link_a_slave_select_n,
  input  wire logic                             i_link_a_serial_clock,
  input  wire logic                             i_link_a_mosi,
  output logic                                  o_link_a_miso,
  output logic                                  o_link_a_miso_oe_n,
  // Serial link B.
  input  wire logic                             i_link_b_slave_select_n,
  input  wire logic                             i_link_b_serial_clock,
  input  wire logic                             i_link_b_mosi,
  output logic                                  o_link_b_miso,
  output logic                                  o_link_b_miso_oe_n,
  // Shared acknowledge.
  output logic                                  o_ack_n
);
  import host_port_pkg::*;

  localparam int unsigned NSYNC    = 25;
  localparam int          ACK_WAIT = int'(ACK_CYCLES);

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic             spa_d;
    logic             spb_d;
    logic             sck_d;
    logic             ss_d;
    logic             we_d;
    sel_t             sel;
    logic [3:0]       bitcnt;
    logic [13:0]      shift;
    logic             rw;
    logic             par;
    logic             overrun;
    logic [7:0]       rd_byte;
    logic             miso;
    logic             ack_n;
    logic             wr_en;
    logic [4:0]       wr_addr;
    logic [7:0]       wr_data;
    logic [7:0]       pdata;
    logic             ppar;
    logic             pdrive;
  } state_t;

  state_t       state_r;
  state_t       state_nxt;
  reg_port_if   rbus ();
  logic [NSYNC-1:0] raw;

  reg_store u_store (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .bus    (rbus.store)
  );

  assign raw = {i_link_a_select_n, i_link_b_select_n, i_parallel_register_address, i_parallel_data_byte,
                i_parallel_parity_bit, i_chip_enable_n, i_output_enable_n, i_write_enable_n,
                i_link_a_slave_select_n, i_link_a_serial_clock, i_link_a_mosi,
                i_link_b_slave_select_n, i_link_b_serial_clock, i_link_b_mosi};

  // Synchronised pin views, all taken from the second stage.
  logic       spa, spb, ce_n, oe_n, we_n, ppin, link_a_slave_select_n, scka, mosia, link_b_slave_select_n, sckb, mosib;
  logic [4:0] paddr;
  logic [7:0] pdin;
  assign {spa, spb, paddr, pdin, ppin, ce_n, oe_n, we_n, link_a_slave_select_n, scka, mosia, link_b_slave_select_n, sckb, mosib} = state_r.s2;

  logic ss_cur, sck_cur, mosi_cur, par_ok, sel_fall;
  always_comb begin
    ss_cur   = (state_r.sel == SEL_LINK_A) ? link_a_slave_select_n : link_b_slave_select_n;
    sck_cur  = (state_r.sel == SEL_LINK_A) ? scka : sckb;
    mosi_cur = (state_r.sel == SEL_LINK_A) ? mosia : mosib;
    par_ok   = ~^{paddr, pdin, ppin};
    sel_fall = (state_r.spa_d && !spa) || (state_r.spb_d && !spb);
  end

  assign rbus.wr_en   = state_r.wr_en;
  assign rbus.wr_addr = state_r.wr_addr;
  assign rbus.wr_data = state_r.wr_data;
  assign rbus.rd_addr = (state_r.sel == SEL_PARALLEL) ? paddr : state_r.shift[4:0];

  always_comb begin
    state_nxt       = state_r;
    state_nxt.s1    = raw;
    state_nxt.s2    = state_r.s1;
    state_nxt.spa_d = spa;
    state_nxt.spb_d = spb;
    state_nxt.sck_d = sck_cur;
    state_nxt.ss_d  = ss_cur;
    state_nxt.we_d  = we_n;
    state_nxt.wr_en = 1'b0;
    // Edge-driven selection; a falling select wins, clears the bit count and blocks writes, but ack_n keeps its value.
    if (state_r.spa_d && !spa) begin
      state_nxt.sel    = SEL_LINK_A;
      state_nxt.bitcnt = '0;
      state_nxt.ss_d   = 1'b1;
    end else if (state_r.spb_d && !spb) begin
      state_nxt.sel    = SEL_LINK_B;
      state_nxt.bitcnt = '0;
      state_nxt.ss_d   = 1'b1;
    end else if (spa && spb) begin
      state_nxt.sel = SEL_PARALLEL;
    end
    state_nxt.pdrive = 1'b0;
    if (state_r.sel == SEL_PARALLEL && state_nxt.sel == SEL_PARALLEL) begin
      state_nxt.ack_n = !(!ce_n && oe_n && par_ok);
      state_nxt.pdrive = !ce_n && !oe_n && we_n;
      state_nxt.pdata  = rbus.rd_data;
      state_nxt.ppar   = ^{paddr, rbus.rd_data};
      if (!ce_n && oe_n && state_r.we_d && !we_n && par_ok && !state_r.ack_n) begin
        state_nxt.wr_en   = 1'b1;
        state_nxt.wr_addr = paddr;
        state_nxt.wr_data = pdin;
      end
    end else if (state_r.sel != SEL_PARALLEL && state_nxt.sel == state_r.sel && !sel_fall) begin
      if (state_r.ss_d && !ss_cur) begin
        state_nxt.bitcnt  = '0;
        state_nxt.par     = 1'b0;
        state_nxt.overrun = 1'b0;
        state_nxt.ack_n   = 1'b1;
        state_nxt.miso    = 1'b0;
      end else if (!ss_cur && !state_r.sck_d && sck_cur) begin
        state_nxt.par = state_r.par ^ mosi_cur;
        if (state_r.bitcnt == 4'(FRAME_BITS)) begin
          state_nxt.overrun = 1'b1;
        end else begin
          state_nxt.bitcnt = state_r.bitcnt + 4'h1;
          if (state_r.bitcnt == 4'h0) begin
            state_nxt.rw = mosi_cur;
          end else begin
            state_nxt.shift = {state_r.shift[12:0], mosi_cur};
          end
        end
      end else if (!ss_cur && state_r.sck_d && !sck_cur) begin
        if (state_r.bitcnt == 4'h6) begin
          // The address has only just been completed, so the byte is fetched here.
          state_nxt.miso    = rbus.rd_data[7];
          state_nxt.rd_byte = {rbus.rd_data[6:0], 1'b0};
        end else if (state_r.bitcnt >= 4'h7 && state_r.bitcnt <= 4'hd) begin
          state_nxt.miso    = state_r.rd_byte[7];
          state_nxt.rd_byte = {state_r.rd_byte[6:0], 1'b0};
        end else begin
          state_nxt.miso = 1'b0;
        end
      end else if (!state_r.ss_d && ss_cur) begin
        // Only a whole frame of correct length and parity writes.
        if (state_r.bitcnt == 4'(FRAME_BITS) && !state_r.overrun && !state_r.par) begin
          state_nxt.ack_n = 1'b0;
          if (!state_r.rw) begin
            state_nxt.wr_en   = 1'b1;
            state_nxt.wr_addr = state_r.shift[13:9];
            state_nxt.wr_data = state_r.shift[8:1];
          end
        end
        state_nxt.bitcnt = '0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_r       <= '0;
      state_r.s1    <= '1;
      state_r.s2    <= '1;
      state_r.spa_d <= 1'b1;
      state_r.spb_d <= 1'b1;
      state_r.ss_d  <= 1'b1;
      state_r.we_d  <= 1'b1;
      state_r.ack_n <= 1'b1;
      state_r.sel   <= SEL_PARALLEL;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_parallel_data_byte   <= 8'h00;
      o_parallel_data_oe_n   <= 1'b1;
      o_parallel_parity_bit  <= 1'b0;
      o_parallel_parity_oe_n <= 1'b1;
      o_link_a_miso          <= 1'b0;
      o_link_a_miso_oe_n     <= 1'b1;
      o_link_b_miso          <= 1'b0;
      o_link_b_miso_oe_n     <= 1'b1;
      o_ack_n                <= 1'b1;
    end else begin
      o_parallel_data_byte   <= state_r.pdata;
      o_parallel_data_oe_n   <= !(state_r.pdrive && state_r.sel == SEL_PARALLEL);
      o_parallel_parity_bit  <= state_r.ppar;
      o_parallel_parity_oe_n <= !(state_r.pdrive && state_r.sel == SEL_PARALLEL);
      o_link_a_miso          <= state_r.miso;
      o_link_a_miso_oe_n     <= !(state_r.sel == SEL_LINK_A && !link_a_slave_select_n);
      o_link_b_miso          <= state_r.miso;
      o_link_b_miso_oe_n     <= !(state_r.sel == SEL_LINK_B && !link_b_slave_select_n);
      o_ack_n                <= state_r.ack_n;
    end
  end

  bad_parity_nowr_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_r.sel == SEL_PARALLEL && state_nxt.sel == SEL_PARALLEL && !par_ok) |=> !state_r.wr_en)
    else $error("write despite parity failure");
  ack_on_parity_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_r.sel == SEL_PARALLEL && !ce_n && oe_n && par_ok && spa && spb && state_r.spa_d && state_r.spb_d)
    |-> ##[1:ACK_WAIT] !o_ack_n)
    else $error("acknowledge late on good parity");
  one_active_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    $countones({!o_parallel_data_oe_n, !o_link_a_miso_oe_n, !o_link_b_miso_oe_n}) <= 1)
    else $error("two interfaces drive at once");
  par_sel_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (spa && spb && state_r.spa_d && state_r.spb_d) |=> state_r.sel == SEL_PARALLEL)
    else $error("parallel not selected");
  fall_sel_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_r.spa_d && !spa) |=> state_r.sel == SEL_LINK_A)
    else $error("link A not selected on falling edge");
  abort_count_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_r.spb_d && !spb) |=> state_r.bitcnt == 4'h0 && !state_r.wr_en)
    else $error("switch did not abort");
  frame_len_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    state_r.wr_en && state_r.sel != SEL_PARALLEL |-> $past(state_r.bitcnt) == 4'(FRAME_BITS))
    else $error("serial write from wrong length frame");
  read_drive_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !o_parallel_data_oe_n |-> ($past(ce_n, 2) == 1'b0 && $past(oe_n, 2) == 1'b0))
    else $error("parallel data driven outside a read");
  ack_par_fail_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_r.sel == SEL_PARALLEL && state_nxt.sel == SEL_PARALLEL && !par_ok) |=> ##1 o_ack_n)
    else $error("acknowledge low on parity failure");
  read_parity_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !o_parallel_data_oe_n |-> ^{$past(paddr, 2), o_parallel_data_byte, o_parallel_parity_bit} == 1'b0)
    else $error("read parity not even");
  link_a_quiet_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    state_r.sel != SEL_LINK_A |=> o_link_a_miso_oe_n)
    else $error("link A output driven while unselected");
  link_b_quiet_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    state_r.sel != SEL_LINK_B |=> o_link_b_miso_oe_n)
    else $error("link B output driven while unselected");
  serial_ack_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_r.sel != SEL_PARALLEL && state_nxt.sel == state_r.sel && !state_r.ack_n
     && !(state_r.ss_d && !ss_cur))
    |=> !state_r.ack_n)
    else $error("serial acknowledge dropped before select fell");
  bad_frame_nowr_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_r.sel != SEL_PARALLEL && state_nxt.sel == state_r.sel && !state_r.ss_d && ss_cur
     && (state_r.par || state_r.bitcnt != 4'(FRAME_BITS)))
    |=> !state_r.wr_en && state_r.ack_n)
    else $error("bad serial frame accepted");
  bit_count_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_r.sel != SEL_PARALLEL && state_nxt.sel == state_r.sel && !sel_fall && !state_r.ss_d && !ss_cur
     && !state_r.sck_d && sck_cur && state_r.bitcnt != 4'(FRAME_BITS))
    |=> state_r.bitcnt == $past(state_r.bitcnt) + 4'h1)
    else $error("serial bit not counted on clock rise");
  serial_write_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_r.wr_en && state_r.sel != SEL_PARALLEL)
    |-> state_r.wr_addr == $past(state_r.shift[13:9]) && state_r.wr_data == $past(state_r.shift[8:1]))
    else $error("serial write fields out of place");
  write_addr_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_r.wr_en && state_r.sel == SEL_PARALLEL) |-> state_r.wr_addr == $past(paddr) && state_r.wr_data == $past(pdin))
    else $error("parallel write to wrong register");
endmodule : host_register_access_port

/* core/host_port_pkg.sv */
// Package with the constants and types shared by the host register access port.
package host_port_pkg;
  localparam int unsigned NUM_REGS       = 32;
  localparam int unsigned ADDR_W         = 5;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned FRAME_BITS     = 15;
  localparam logic [4:0]  FIRST_UNIMPL   = 5'h1a;
  localparam logic [7:0]  REG_RESET_VAL  = 8'h00;
  localparam logic [7:0]  UNIMPL_READ    = 8'h00;
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned ACK_MAX_PS     = 20000;
  localparam int unsigned ACK_CYCLES     = (ACK_MAX_PS / CLK_PERIOD_PS < 1) ? 1 : ACK_MAX_PS / CLK_PERIOD_PS;
  localparam int unsigned RD_VALID_PS    = 10000;
  localparam int unsigned RD_CYCLES      = (RD_VALID_PS / CLK_PERIOD_PS < 1) ? 1 : RD_VALID_PS / CLK_PERIOD_PS;
  localparam int unsigned FRAME_CNT_W    = 4;

  typedef enum logic [1:0] {
    SEL_PARALLEL,
    SEL_LINK_A,
    SEL_LINK_B
  } sel_t;

  function automatic logic is_writable(input logic [4:0] addr);
    return addr < FIRST_UNIMPL;
  endfunction : is_writable
endpackage : host_port_pkg

/* core/reg_port_if.sv */
// Interface carrying register write and read traffic between the port and its register store.
interface reg_port_if;
  logic       wr_en;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;
  logic [4:0] rd_addr;
  logic [7:0] rd_data;

  modport master (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : reg_port_if

/* core/reg_store.sv */
// Register store of 32 byte-wide locations with the unimplemented range masked.
module reg_store
  import host_port_pkg::*;
(
  // Clock and reset.
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // Register traffic.
  reg_port_if.store bus
);
  import host_port_pkg::*;

  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] mem;
  } store_t;

  store_t state_r;
  store_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (bus.wr_en && is_writable(bus.wr_addr)) begin
      state_nxt.mem[bus.wr_addr] = bus.wr_data;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= '{default: '0};
    end else begin
      state_r <= state_nxt;
    end
  end

  // Unimplemented addresses always read as zero.
  assign bus.rd_data = is_writable(bus.rd_addr) ? state_r.mem[bus.rd_addr] : UNIMPL_READ;

  unimpl_stays_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !is_writable(bus.rd_addr) |-> bus.rd_data == 8'h00)
    else $error("unimplemented register read nonzero");
endmodule : reg_store

/* dv/host_model.sv */
// Host-side model that drives the parallel bus, the select pins and both serial links.
module host_model (
  // Clock and acknowledge.
  input  wire logic       i_mclk,
  input  wire logic       i_ack_n,
  // Select pins and parallel bus.
  output logic            o_sel_a_n,
  output logic            o_sel_b_n,
  output logic [4:0]      o_addr,
  output logic [7:0]      o_data,
  output logic            o_par,
  output logic            o_ce_n,
  output logic            o_oe_n,
  output logic            o_we_n,
  // Serial links; clock and data lines are routed in common.
  output logic            o_ss_a_n,
  output logic            o_ss_b_n,
  output logic            o_sck,
  output logic            o_mosi,
  input  wire logic       i_miso_a,
  input  wire logic       i_miso_b
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {o_sel_a_n, o_sel_b_n, o_ce_n, o_oe_n, o_we_n, o_ss_a_n, o_ss_b_n} = 7'h7f;
    {o_addr, o_data, o_par, o_sck, o_mosi} = 16'h0000;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : cyc

  task automatic sel(input logic a_n, input logic b_n);
    o_sel_a_n = a_n;
    o_sel_b_n = b_n;
    cyc(5);
  endtask : sel

  task automatic par_write(input logic [4:0] a, input logic [7:0] d, input logic bad, input logic hold,
                           output logic ack_n);
    o_oe_n = 1'b1;
    o_ce_n = 1'b0;
    o_addr = a;
    o_data = d;
    o_par  = ^{a, d} ^ bad;
    cyc(6);
    ack_n  = i_ack_n;
    o_we_n = 1'b0;
    cyc(4);
    o_we_n = 1'b1;
    cyc(4);
    if (!hold) o_ce_n = 1'b1;
    o_data = ~d;
    cyc(4);
  endtask : par_write

  task automatic par_read(input logic [4:0] a);
    o_we_n = 1'b1;
    o_ce_n = 1'b0;
    o_addr = a;
    cyc(3);
    o_oe_n = 1'b0;
    cyc(8);
    o_oe_n = 1'b1;
    cyc(5);
    o_ce_n = 1'b1;
    cyc(4);
  endtask : par_read

  // An abort lowers link A's select before the slave select rises.
  task automatic serial(input logic lb, input logic [14:0] f, input int nbits, input logic abort,
                        output logic [7:0] rd);
    rd = 8'h00;
    if (lb) o_ss_b_n = 1'b0; else o_ss_a_n = 1'b0;
    cyc(4);
    for (int i = 0; i < nbits; i++) begin
      o_mosi = f[14-i];
      cyc(8);
      if (i >= 6 && i <= 13) rd = {rd[6:0], lb ? i_miso_b : i_miso_a};
      o_sck = 1'b1;
      cyc(8);
      o_sck = 1'b0;
    end
    o_mosi = ~o_mosi;
    if (abort) o_sel_a_n = 1'b0;
    cyc(6);
    o_ss_a_n = 1'b1;
    o_ss_b_n = 1'b1;
    cyc(10);
  endtask : serial
endmodule : host_model

/* dv/host_register_access_port_tb.sv */
// Self-checking bench for the host register access port.
module host_register_access_port_tb import host_port_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_mclk, i_rst, sel_a_n, sel_b_n, par, ce_n, oe_n, we_n, ss_a_n, ss_b_n, sck, mosi;
  logic        dut_par, data_oe_n, par_oe_n, miso_a, miso_a_oe_n, miso_b, miso_b_oe_n, ack_n, got_ack;
  logic [4:0]  addr;
  logic [7:0]  host_data, dut_data, rd, mem [32];
  logic [8:0]  exp_q [$];
  logic [31:0] seed;
  int          num_errors, n_tests, cycles;

  host_model i_host (.i_mclk(i_mclk), .i_ack_n(ack_n), .o_sel_a_n(sel_a_n), .o_sel_b_n(sel_b_n), .o_addr(addr),
    .o_data(host_data), .o_par(par), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_ss_a_n(ss_a_n),
    .o_ss_b_n(ss_b_n), .o_sck(sck), .o_mosi(mosi), .i_miso_a(miso_a), .i_miso_b(miso_b));

  host_register_access_port i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_link_a_select_n(sel_a_n),
    .i_link_b_select_n(sel_b_n), .i_parallel_register_address(addr),
    .i_parallel_data_byte(data_oe_n ? host_data : dut_data), .o_parallel_data_byte(dut_data),
    .o_parallel_data_oe_n(data_oe_n), .i_parallel_parity_bit(par_oe_n ? par : dut_par),
    .o_parallel_parity_bit(dut_par), .o_parallel_parity_oe_n(par_oe_n), .i_chip_enable_n(ce_n),
    .i_output_enable_n(oe_n), .i_write_enable_n(we_n), .i_link_a_slave_select_n(ss_a_n),
    .i_link_a_serial_clock(sck), .i_link_a_mosi(mosi), .o_link_a_miso(miso_a), .o_link_a_miso_oe_n(miso_a_oe_n),
    .i_link_b_slave_select_n(ss_b_n), .i_link_b_serial_clock(sck), .i_link_b_mosi(mosi), .o_link_b_miso(miso_b),
    .o_link_b_miso_oe_n(miso_b_oe_n), .o_ack_n(ack_n));

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // Every parallel read result is compared with the oldest note.
  always @(negedge data_oe_n) begin
    #1;
    if (exp_q.size() == 0) check(16'hffff, 16'h0000);
    else check({par_oe_n, dut_par, dut_data}, {1'b0, exp_q.pop_front()});
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic pwrite(input logic [4:0] a, input logic [7:0] d, input logic bad, input logic hold);
    i_host.par_write(a, d, bad, hold, got_ack);
    check(got_ack, bad);
    if (!bad && a < FIRST_UNIMPL) mem[a] = d;
  endtask : pwrite

  task automatic pread(input logic [4:0] a);
    exp_q.push_back({^{a, mem[a]}, mem[a]});
    i_host.par_read(a);
  endtask : pread

  task automatic swr(input logic lb, input logic [4:0] a, input logic [7:0] d, input int n, input logic bad,
                     input logic abort);
    i_host.serial(lb, {1'b0, a, d, ^{a, d} ^ bad}, n, abort, rd);
    if (!abort) check(ack_n, bad || n != 15);
    if (n == 15 && !abort && !bad && a < FIRST_UNIMPL) mem[a] = d;
  endtask : swr

  task automatic srd(input logic lb, input logic [4:0] a);
    i_host.serial(lb, {1'b1, a, 8'h00, ~^a}, 15, 1'b0, rd);
    check(rd, mem[a]);
  endtask : srd

  initial begin
    {num_errors, n_tests, cycles} = '0;
    seed = 32'd54;
    foreach (mem[i]) mem[i] = REG_RESET_VAL;
    i_rst = 1'b1;
    repeat (6) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    i_host.cyc(3);
    for (int a = 0; a < 32; a++) begin
      seed = xs(seed);
      pwrite(a[4:0], seed[7:0], 1'b0, a != 31);
    end
    for (int a = 0; a < 32; a++) pread(a[4:0]);
    pwrite(5'h03, ~mem[3], 1'b1, 1'b0);
    pread(5'h03);
    $display("parallel test done");
    i_host.sel(1'b0, 1'b1);
    check({miso_b_oe_n, data_oe_n}, 16'h0003);
    swr(1'b0, 5'h05, 8'ha5, 15, 1'b0, 1'b0);
    srd(1'b0, 5'h05);
    swr(1'b0, 5'h05, 8'h3c, 15, 1'b1, 1'b0);
    swr(1'b0, 5'h05, 8'h3c, 14, 1'b0, 1'b0);
    srd(1'b0, 5'h05);
    srd(1'b0, 5'h1c);
    $display("link a test done");
    i_host.sel(1'b0, 1'b0);
    i_host.sel(1'b1, 1'b0);
    check(miso_a_oe_n, 1'b1);
    swr(1'b1, 5'h19, 8'h5a, 15, 1'b0, 1'b0);
    srd(1'b1, 5'h19);
    swr(1'b1, 5'h06, 8'hc3, 15, 1'b0, 1'b1);
    i_host.sel(1'b0, 1'b1);
    srd(1'b0, 5'h06);
    $display("link b test done");
    i_host.sel(1'b1, 1'b1);
    for (int a = 0; a < 32; a++) pread(a[4:0]);
    i_host.cyc(10);
    check(16'(exp_q.size()), 16'h0000);
    $display("readback test done");
    report_and_stop();
  end
endmodule : host_register_access_port_tb
